/* File: rtl/evq_cfg_pkg.sv */
// constants for the event queue and msi configuration register group
package evq_cfg_pkg;
  // ==========================================================
  // register offsets within the page
  localparam logic [15:0] OFF_EVQ_BASE   = 16'h00A0;
  localparam logic [15:0] OFF_MSI_ADDR   = 16'h00B0;
  localparam logic [15:0] OFF_MSI_DATA   = 16'h00B8;
  localparam logic [15:0] OFF_MSI_ATTR   = 16'h00BC;
  localparam logic [15:0] OFF_PRIQ_BASE  = 16'h00C0;
  // ==========================================================
  // field layout of the queue base registers
  localparam int HINT_BIT      = 62;
  localparam int QADDR_HI      = 51;
  localparam int QADDR_LO      = 5;
  localparam int QSIZE_HI      = 4;
  localparam int QSIZE_W       = 5;
  localparam int MIN_ALIGN_LG2 = 5;
  localparam int ENTRY_LG2     = 5;
  // ==========================================================
  // field layout of the msi registers
  localparam int MADDR_HI  = 51;
  localparam int MADDR_LO  = 2;
  localparam int DOM_HI    = 5;
  localparam int DOM_LO    = 4;
  localparam int MT_HI     = 3;
  // ==========================================================
  // shareability encodings
  localparam logic [1:0] DOM_NON   = 2'h0;
  localparam logic [1:0] DOM_RSVD  = 2'h1;
  localparam logic [1:0] DOM_OUTER = 2'h2;
  localparam logic [1:0] DOM_INNER = 2'h3;
  // memory types with top two bits clear are device types
  localparam logic [1:0] MT_DEVICE_TOP = 2'h0;
  // ==========================================================
  // preset reset values when configuration is fixed
  localparam logic        PRESET_HINT = 1'h0;
  localparam logic [46:0] PRESET_ADDR = 47'h0;
  localparam logic [4:0]  PRESET_SIZE = 5'h0;
endpackage : evq_cfg_pkg

/* File: rtl/word_guard.sv */
// one guarded 32-bit register word with write gating
`timescale 1ns/1ps
module word_guard #(
  parameter logic [31:0] RESET_VAL = 32'h0,
  parameter logic [31:0] KEEP_MASK = 32'hFFFFFFFF
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // write side
  input  wire logic        wr_i,
  input  wire logic        open_i,
  input  wire logic [31:0] wdata_i,
  // stored value
  output logic      [31:0] q_o
);
  typedef struct packed {
    logic [31:0] val;
  } state_t;
  state_t st;
  state_t next_st;

  // ==========================================================
  // store only while the guard is open
  always_comb begin
    next_st = st;
    if (wr_i && open_i) begin
      next_st.val = wdata_i & KEEP_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st.val <= RESET_VAL & KEEP_MASK;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.val;
endmodule : word_guard

/* File: rtl/event_queue_msi_config.sv */
// event queue base and msi configuration register group
`timescale 1ns/1ps
// Operation
// - write-allocate hint drives event queue writes
// - base address from bits 51:5 only
// - bits above address width read zero
// - base aligned to max(queue bytes, 32)
// - size capped internally, raw value read back
// - fixed config resets fields to preset values
// - events written only while queue enabled
// - base writes ignored while queue enabled
// - base writable only unfixed, enable and ack clear
// - msi address bits 51:2, low bits zero
// - no msi while target address zero
// - msi registers writable only with gate, ack clear
// - shareability decode, reserved treated as non-shareable
// - device memory type forces outer shareable
// - memory type passed as stream table entry encoding
// - msi registers absent read zero without support
// - page request base present only with support
module event_queue_msi_config #(
  parameter int PA_W      = 48,
  parameter int MAX_EQ_LG = 19,
  parameter bit HAS_MSI   = 1'b1,
  parameter bit HAS_PRI   = 1'b1
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register access, one 32-bit word per cycle
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  // control bits and their acknowledge copies
  input  wire logic        fixed_queue_config_i,
  input  wire logic        event_queue_on_i,
  input  wire logic        control_ack_copy_i,
  input  wire logic        event_irq_gate_i,
  input  wire logic        interrupt_gate_ack_i,
  input  wire logic        pri_queue_on_i,
  input  wire logic        pri_ack_copy_i,
  // event source and queue write request
  input  wire logic        event_valid_i,
  input  wire logic        queue_writable_i,
  input  wire logic        event_irq_i,
  output logic             queue_wr_o,
  output logic             queue_hint_o,
  output logic      [51:0] queue_base_o,
  output logic      [4:0]  queue_size_o,
  // msi write request
  output logic             msi_wr_o,
  output logic      [51:0] msi_addr_o,
  output logic      [31:0] msi_data_o,
  output logic      [1:0]  msi_coherency_domain_o,
  output logic      [3:0]  msi_memory_type_o
);
  // bits that survive the address width limit in each high word
  localparam logic [31:0] HI_ADDR_MASK = 32'((64'h1 << (PA_W - 32)) - 64'h1);
  localparam logic [31:0] BASE_HI_MASK = HI_ADDR_MASK | 32'h40000000;
  localparam logic [31:0] BASE_LO_MASK = 32'hFFFFFFFF;
  localparam logic [31:0] MLO_MASK     = 32'hFFFFFFFC;
  localparam logic [31:0] ATTR_MASK    = 32'h0000003F;
  localparam logic [31:0] PRESET_LO    =
    {evq_cfg_pkg::PRESET_ADDR[26:0], evq_cfg_pkg::PRESET_SIZE};
  localparam logic [31:0] PRESET_HI    =
    {1'b0, evq_cfg_pkg::PRESET_HINT, 10'h0, evq_cfg_pkg::PRESET_ADDR[46:27]};

  typedef struct packed {
    logic [31:0] rdata;
    logic        qwr;
    logic        qwa;
    logic [51:0] qbase;
    logic [4:0]  qsize;
    logic        mwr;
    logic [51:0] maddr;
    logic [31:0] mdata;
    logic [1:0]  msh;
    logic [3:0]  mtype;
    logic        fixed;
  } state_t;
  state_t st;
  state_t next_st;

  // ==========================================================
  // guards
  logic base_open;
  logic msi_open;
  logic pri_open;
  assign base_open = !fixed_queue_config_i && !event_queue_on_i
                     && !control_ack_copy_i;
  assign msi_open  = HAS_MSI && !event_irq_gate_i && !interrupt_gate_ack_i;
  assign pri_open  = HAS_PRI && !pri_queue_on_i && !pri_ack_copy_i;

  // word write strobes
  logic w_blo, w_bhi, w_mlo, w_mhi, w_md, w_ma, w_plo, w_phi;
  assign w_blo = wr_i && addr_i == evq_cfg_pkg::OFF_EVQ_BASE;
  assign w_bhi = wr_i && addr_i == evq_cfg_pkg::OFF_EVQ_BASE + 16'h0004;
  assign w_mlo = wr_i && addr_i == evq_cfg_pkg::OFF_MSI_ADDR;
  assign w_mhi = wr_i && addr_i == evq_cfg_pkg::OFF_MSI_ADDR + 16'h0004;
  assign w_md  = wr_i && addr_i == evq_cfg_pkg::OFF_MSI_DATA;
  assign w_ma  = wr_i && addr_i == evq_cfg_pkg::OFF_MSI_ATTR;
  assign w_plo = wr_i && addr_i == evq_cfg_pkg::OFF_PRIQ_BASE;
  assign w_phi = wr_i && addr_i == evq_cfg_pkg::OFF_PRIQ_BASE + 16'h0004;

  // ==========================================================
  // storage words
  logic [31:0] base_lo, base_hi, mlo, mhi, mdat, mattr, plo, phi;
  logic        fixed_q;

  // preset loads each cycle while the registered fixed flag is set, one cycle behind fixed_queue_config_i
  assign fixed_q = st.fixed;

  // event queue base low word: address low part and size
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (BASE_LO_MASK)
  ) u_base_lo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_blo || fixed_q),
    .open_i  (base_open || fixed_q),
    .wdata_i (fixed_q ? PRESET_LO : wdata_i),
    .q_o     (base_lo)
  );
  // event queue base high word: hint and address high part
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (BASE_HI_MASK)
  ) u_base_hi (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_bhi || fixed_q),
    .open_i  (base_open || fixed_q),
    .wdata_i (fixed_q ? PRESET_HI : wdata_i),
    .q_o     (base_hi)
  );
  // msi target address low word
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (MLO_MASK)
  ) u_mlo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_mlo),
    .open_i  (msi_open),
    .wdata_i (wdata_i),
    .q_o     (mlo)
  );
  // msi target address high word
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (HI_ADDR_MASK)
  ) u_mhi (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_mhi),
    .open_i  (msi_open),
    .wdata_i (wdata_i),
    .q_o     (mhi)
  );
  // msi payload word
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (32'hFFFFFFFF)
  ) u_mdat (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_md),
    .open_i  (msi_open),
    .wdata_i (wdata_i),
    .q_o     (mdat)
  );
  // msi coherency domain and memory type
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (ATTR_MASK)
  ) u_mattr (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_ma),
    .open_i  (msi_open),
    .wdata_i (wdata_i),
    .q_o     (mattr)
  );
  // page request queue base low word
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (BASE_LO_MASK)
  ) u_plo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_plo),
    .open_i  (pri_open),
    .wdata_i (wdata_i),
    .q_o     (plo)
  );
  // page request queue base high word
  word_guard #(
    .RESET_VAL (32'h0),
    .KEEP_MASK (BASE_HI_MASK)
  ) u_phi (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_i    (w_phi),
    .open_i  (pri_open),
    .wdata_i (wdata_i),
    .q_o     (phi)
  );

  // ==========================================================
  // derived queue values
  logic [63:0] base_raw;
  logic [4:0]  size_cap;
  logic [51:0] align_mask;
  logic [51:0] base_eff;
  logic [5:0]  align_lg2;
  assign base_raw = {base_hi, base_lo};
  assign size_cap = (base_raw[evq_cfg_pkg::QSIZE_HI:0] > 5'(MAX_EQ_LG))
                    ? 5'(MAX_EQ_LG) : base_raw[evq_cfg_pkg::QSIZE_HI:0];
  assign align_lg2 = 6'(size_cap) + 6'(evq_cfg_pkg::ENTRY_LG2);
  assign align_mask = ~((52'h1 << align_lg2) - 52'h1);
  assign base_eff = {base_raw[evq_cfg_pkg::QADDR_HI:evq_cfg_pkg::QADDR_LO],
                     5'h00} & align_mask;

  // msi derived values
  logic [51:0] maddr;
  logic [1:0]  dom_raw;
  logic [3:0]  mtype;
  logic [1:0]  dom_eff;
  assign maddr   = {mhi[19:0], mlo[31:evq_cfg_pkg::MADDR_LO], 2'h0};
  assign dom_raw = mattr[evq_cfg_pkg::DOM_HI:evq_cfg_pkg::DOM_LO];
  assign mtype   = mattr[evq_cfg_pkg::MT_HI:0];

  // shareability decode with device override
  always_comb begin
    unique case (dom_raw)
      evq_cfg_pkg::DOM_RSVD: dom_eff = evq_cfg_pkg::DOM_NON;
      default:               dom_eff = dom_raw;
    endcase
    if (mtype[3:2] == evq_cfg_pkg::MT_DEVICE_TOP) begin
      dom_eff = evq_cfg_pkg::DOM_OUTER;
    end
  end

  // ==========================================================
  // next state: read mux, queue write and msi requests
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        evq_cfg_pkg::OFF_EVQ_BASE:            next_st.rdata = base_lo;
        evq_cfg_pkg::OFF_EVQ_BASE + 16'h0004: next_st.rdata = base_hi;
        evq_cfg_pkg::OFF_MSI_ADDR:            next_st.rdata = HAS_MSI ? mlo : 32'h0;
        evq_cfg_pkg::OFF_MSI_ADDR + 16'h0004: next_st.rdata = HAS_MSI ? mhi : 32'h0;
        evq_cfg_pkg::OFF_MSI_DATA:            next_st.rdata = HAS_MSI ? mdat : 32'h0;
        evq_cfg_pkg::OFF_MSI_ATTR:            next_st.rdata = HAS_MSI ? mattr : 32'h0;
        evq_cfg_pkg::OFF_PRIQ_BASE:           next_st.rdata = HAS_PRI ? plo : 32'h0;
        evq_cfg_pkg::OFF_PRIQ_BASE + 16'h0004: next_st.rdata = HAS_PRI ? phi : 32'h0;
        default:                              next_st.rdata = 32'h0;
      endcase
    end
    next_st.qwr   = event_valid_i && event_queue_on_i && queue_writable_i;
    next_st.qwa   = base_raw[evq_cfg_pkg::HINT_BIT];
    next_st.qbase = base_eff;
    next_st.qsize = size_cap;
    next_st.mwr   = HAS_MSI && event_irq_i && event_irq_gate_i
                    && (maddr != 52'h0);
    next_st.maddr = maddr;
    next_st.mdata = mdat;
    next_st.msh   = dom_eff;
    next_st.mtype = mtype;
    next_st.fixed = fixed_queue_config_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign rdata_o                = st.rdata;
  assign queue_wr_o             = st.qwr;
  assign queue_hint_o           = st.qwa;
  assign queue_base_o           = st.qbase;
  assign queue_size_o           = st.qsize;
  assign msi_wr_o               = st.mwr;
  assign msi_addr_o             = st.maddr;
  assign msi_data_o             = st.mdata;
  assign msi_coherency_domain_o = st.msh;
  assign msi_memory_type_o      = st.mtype;
endmodule : event_queue_msi_config

/* File: sim/event_queue_msi_config_chk.sv */
// assertions on the event queue and msi configuration outputs
`timescale 1ns/1ps
module event_queue_msi_config_chk #(
  parameter int PA_W      = 48,
  parameter int MAX_EQ_LG = 19
) (
  // clock, reset and causes
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        event_valid_i,
  input wire logic        event_queue_on_i,
  input wire logic        queue_writable_i,
  input wire logic        event_irq_i,
  // watched outputs
  input wire logic        queue_wr_o,
  input wire logic [51:0] queue_base_o,
  input wire logic [4:0]  queue_size_o,
  input wire logic        msi_wr_o,
  input wire logic [51:0] msi_addr_o,
  input wire logic [1:0]  msi_coherency_domain_o,
  input wire logic [3:0]  msi_memory_type_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // output relations
  a_queue_wr_cause: assert property ($past(rst_n_i) |-> queue_wr_o ==
    $past(event_valid_i && event_queue_on_i && queue_writable_i)) else $error("queue write");
  a_base_aligned: assert property (
    (queue_base_o & ((52'h1 << (queue_size_o + 5)) - 52'h1)) == 52'h0) else $error("base align");
  a_base_width: assert property ((queue_base_o >> PA_W) == 52'h0) else $error("base high");
  a_size_capped: assert property (queue_size_o <= MAX_EQ_LG) else $error("size cap");
  a_msi_cause: assert property (msi_wr_o |-> $past(event_irq_i) && msi_addr_o != 52'h0)
    else $error("msi cause");
  a_msi_addr_low: assert property (msi_addr_o[1:0] == 2'h0 && (msi_addr_o >> PA_W) == 52'h0)
    else $error("msi addr");
  a_msi_dev_outer: assert property ($past(rst_n_i) && msi_memory_type_o[3:2] == 2'h0
    |-> msi_coherency_domain_o == evq_cfg_pkg::DOM_OUTER) else $error("device outer");
  a_msi_no_rsvd: assert property (msi_coherency_domain_o != evq_cfg_pkg::DOM_RSVD)
    else $error("reserved sh");
  // main scenarios reached
  c_msi_sent: cover property (msi_wr_o);
  c_queue_wr: cover property (queue_wr_o);
  c_size_max: cover property (queue_size_o == MAX_EQ_LG);
endmodule : event_queue_msi_config_chk
bind event_queue_msi_config event_queue_msi_config_chk #(.PA_W(PA_W), .MAX_EQ_LG(MAX_EQ_LG)) chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .event_valid_i(event_valid_i),
  .event_queue_on_i(event_queue_on_i), .queue_writable_i(queue_writable_i),
  .event_irq_i(event_irq_i), .queue_wr_o(queue_wr_o), .queue_base_o(queue_base_o),
  .queue_size_o(queue_size_o), .msi_wr_o(msi_wr_o), .msi_addr_o(msi_addr_o),
  .msi_coherency_domain_o(msi_coherency_domain_o), .msi_memory_type_o(msi_memory_type_o));

/* File: sim/test_event_queue_msi_config.sv */
// self-checking bench for the event queue and msi configuration group
`timescale 1ns/1ps
module test_event_queue_msi_config;
  localparam int PAW = 40;
  localparam logic [51:0] AM = (52'h1 << PAW) - 52'h1;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [15:0] addr_i = 16'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, msi_data_o, lo, hi, d;
  logic        fix = 0, on = 0, ack = 0, gate = 0, gack = 0, pon = 0, pack = 0;
  logic        ev = 0, wbl = 0, irq = 0, queue_wr_o, queue_hint_o, msi_wr_o;
  logic [51:0] queue_base_o, msi_addr_o;
  logic [4:0]  queue_size_o, sz;
  logic [1:0]  msi_coherency_domain_o;
  logic [3:0]  msi_memory_type_o;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  event_queue_msi_config #(.PA_W(PAW), .MAX_EQ_LG(10)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .fixed_queue_config_i(fix), .event_queue_on_i(on), .control_ack_copy_i(ack),
    .event_irq_gate_i(gate), .interrupt_gate_ack_i(gack), .pri_queue_on_i(pon),
    .pri_ack_copy_i(pack), .event_valid_i(ev), .queue_writable_i(wbl), .event_irq_i(irq),
    .queue_wr_o(queue_wr_o), .queue_hint_o(queue_hint_o), .queue_base_o(queue_base_o),
    .queue_size_o(queue_size_o), .msi_wr_o(msi_wr_o), .msi_addr_o(msi_addr_o),
    .msi_data_o(msi_data_o), .msi_coherency_domain_o(msi_coherency_domain_o),
    .msi_memory_type_o(msi_memory_type_o));
  // clock and hang limit
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one register word access, held for one taking edge
  task automatic acc(logic w, logic [15:0] a, logic [31:0] dt);
    @(posedge clk_i);
    #1;
    {wr_i, rd_i, addr_i, wdata_i} = {w, !w, a, dt};
    @(posedge clk_i);
    #1;
    {wr_i, rd_i} = 2'h0;
  endtask : acc
  task automatic rdc(logic [15:0] a, logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk("rdata", e, rdata_o);
  endtask : rdc
  function automatic logic [1:0] cdom(logic [5:0] t);
    return (t[3:2] == 2'h0) ? 2'h2 : ((t[5:4] == 2'h1) ? 2'h0 : t[5:4]);
  endfunction : cdom
  initial begin
    void'($urandom(32'h3C6B1CF0));
    repeat (3) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    // queue base with random fields, two sizes at and above the cap
    for (int i = 0; i < 6; i++) begin
      lo = $urandom;
      hi = $urandom;
      if (i < 2) lo[4:0] = i ? 5'h0A : 5'h1F;
      sz = (lo[4:0] > 5'h0A) ? 5'h0A : lo[4:0];
      acc(1'b1, 16'h00A0, lo);
      acc(1'b1, 16'h00A4, hi);
      rdc(16'h00A0, lo);
      rdc(16'h00A4, hi & 32'h400000FF);
      chk("base", (({hi[19:0], lo[31:5], 5'h0} & AM) >> (sz + 5)) << (sz + 5), queue_base_o);
      chk("size", sz, queue_size_o);
      chk("hint", hi[30], queue_hint_o);
    end
    // base refused while enabled, acknowledged or fixed
    for (int i = 0; i < 3; i++) begin
      {fix, ack, on} = 3'(1 << i);
      acc(1'b1, 16'h00A0, ~lo);
      rdc(16'h00A0, (i == 2) ? 32'h0 : lo);
    end
    {fix, ack, on} = 3'h0;
    // event writes follow enable and writable
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1 {ev, on, wbl} = 3'($urandom);
      @(posedge clk_i);
      #1 chk("qwr", ev & on & wbl, queue_wr_o);
    end
    on = 1'b0;
    // msi target, payload and every attribute code
    for (int i = 0; i < 64; i++) begin
      {lo, hi, d} = {$urandom, $urandom, $urandom};
      acc(1'b1, 16'h00B0, lo);
      acc(1'b1, 16'h00B4, hi);
      acc(1'b1, 16'h00B8, d);
      acc(1'b1, 16'h00BC, 32'(i));
      rdc(16'h00B0, lo & 32'hFFFFFFFC);
      rdc(16'h00BC, 32'(i));
      chk("maddr", {hi[19:0], lo[31:2], 2'h0} & AM, msi_addr_o);
      chk("mdata", d, msi_data_o);
      chk("mtype", i[3:0], msi_memory_type_o);
      chk("mdom", cdom(i[5:0]), msi_coherency_domain_o);
    end
    // msi sent only to a nonzero target
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 16'h00B0, i ? 32'h0 : 32'h00001000);
      acc(1'b1, 16'h00B4, 32'h0);
      @(posedge clk_i);
      #1 {gate, irq} = 2'h3;
      @(posedge clk_i);
      #1 {gate, irq} = 2'h0;
      chk("msi", i == 0, msi_wr_o);
    end
    // msi and page request words refused behind their gates
    for (int i = 0; i < 2; i++) begin
      {gack, gate} = 2'(1 << i);
      acc(1'b1, 16'h00B8, ~d);
      rdc(16'h00B8, d);
    end
    {gack, gate} = 2'h0;
    acc(1'b1, 16'h00C4, 32'h40000000);
    rdc(16'h00C4, 32'h40000000);
    for (int i = 0; i < 2; i++) begin
      {pack, pon} = 2'(1 << i);
      acc(1'b1, 16'h00C4, 32'h0);
      rdc(16'h00C4, 32'h40000000);
    end
    rdc(16'h00A8, 32'h0);
    stop_test();
  end
endmodule : test_event_queue_msi_config
